// *** rtl/ecmbx_pkg.sv ***
// Package of constants and types for the echo canceller host mailbox port
package ecmbx_pkg;
    // ==========================================================
    // Mailbox geometry
    localparam int MBX_BYTES = 3;
    localparam logic [7:0] IDX_LOW  = 8'h00;
    localparam logic [1:0] BYTE_CNT_LAST = 2'h2;
    // ==========================================================
    // Configuration patterns seen in the incoming mailbox (byte2,byte1,byte0)
    localparam logic [23:0] CFG_START_PAT = 24'h00a0aa;
    localparam logic [23:0] CONV_START_PAT = 24'h01aaaa;
    localparam logic [15:0] DELAY_LIMIT   = 16'h0bb8;
    // ==========================================================
    // Local RAM access geometry
    localparam int RAM_DATA_W = 16;
    localparam int RAM_HI_W   = 4;
    // ==========================================================
    // Mailbox engine states
    typedef enum logic [2:0] {
        ECMBX_IDLE   = 3'b000,
        ECMBX_RAM    = 3'b001,
        ECMBX_OFFER  = 3'b010,
        ECMBX_XFER   = 3'b011,
        ECMBX_ACK    = 3'b100
    } ecmbx_state_t;

    // Host handshake inputs grouped together
    typedef struct packed {
        logic host_select_n;
        logic register_select;
        logic system_strobe_n;
        logic system_direction;
    } ecmbx_host_t;

    // Local RAM request from the core
    typedef struct packed {
        logic        read_req;
        logic        write_req;
        logic [11:0] addr;
        logic [15:0] wdata;
    } ecmbx_ram_req_t;

    // Configuration state decoded from mailbox traffic
    typedef struct packed {
        logic        configuring;
        logic        delay_valid;
        logic [15:0] round_trip;
        logic        far_enable;
        logic        near_adapt;
    } ecmbx_cfg_t;
endpackage

// *** rtl/ecmbx_port.sv ***
// Host mailbox port, local RAM bus and half-rate clock of the echo canceller
`timescale 1ns/1ns
// What this block does
// - Output clock at half input rate
// - Host data over 8-bit two-way bus
// - Byte bus carries RAM address, host excluded
// - RAM data on 16-bit bus with strobes
// - RAM address bits 8-11 on own pins
// - Acknowledge output marks recognised host access
// - Bus-available output tells host bus free
// - Attention request invites host to mailbox
// - Device starts every exchange itself
// - Outgoing data sits in three-byte register
// - Host writes land in three-byte register
// - Host may deselect during exchange
// - Handshake alone, asynchronous to host
// - Host reads low then high, writes
// - After reset wait for start pattern
// - Next exchange: delay and far-end enable
// - Convergence pattern enables near-end adaptation
module ecmbx_port
    import ecmbx_pkg::*;
#(
    parameter int RAM_W = ecmbx_pkg::RAM_DATA_W
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    output logic                           half_rate_clock_output,
    input  wire ecmbx_pkg::ecmbx_host_t    host_in,
    input  wire logic [7:0]                sys_bus_in,
    output logic [7:0]                     sys_bus_out,
    output logic                           sys_bus_oe,
    output logic                           transfer_ack_out_n,
    output logic                           bus_available,
    output logic                           attention_req_n,
    input  wire ecmbx_pkg::ecmbx_ram_req_t ram_req,
    output logic                           ram_busy,
    output logic [RAM_W-1:0]               ram_rdata,
    output logic                           ram_rvalid,
    input  wire logic [RAM_W-1:0]          local_data_in,
    output logic [RAM_W-1:0]               local_data_out,
    output logic                           local_data_oe,
    output logic [3:0]                     local_addr_hi,
    output logic                           local_read_n,
    output logic                           local_write_n,
    input  wire logic                      send_valid,
    input  wire logic [23:0]               send_word,
    output logic                           send_ready,
    output logic [23:0]                    recv_word,
    output logic                           recv_valid,
    output ecmbx_pkg::ecmbx_cfg_t          cfg
);
    import ecmbx_pkg::*;

    // ==========================================================
    // Registers
    ecmbx_state_t state_reg, state_next;
    logic         half_clk_reg;
    logic [23:0]  out_mbx_reg;
    logic [23:0]  in_mbx_reg;
    logic [1:0]   rd_cnt_reg, wr_cnt_reg;
    logic         strobe_d_reg;
    logic         ram_write_reg;
    logic [7:0]   bus_out_reg;
    logic [15:0]  rdata_reg;
    logic         rvalid_reg;
    logic         recv_valid_reg;
    ecmbx_cfg_t   cfg_reg;
    logic         ack_reg;

    // ==========================================================
    // Host access decode; strobe is edge-detected so host timing does not matter
    wire host_sel     = ~host_in.host_select_n & host_in.register_select;
    wire strobe_on    = ~host_in.system_strobe_n;
    wire strobe_rise  = strobe_on & ~strobe_d_reg;
    wire in_xfer      = (state_reg == ECMBX_XFER);
    wire host_access  = in_xfer & host_sel & strobe_rise;
    wire host_read    = host_access & host_in.system_direction;
    wire host_write   = host_access & ~host_in.system_direction;
    wire xfer_done    = (rd_cnt_reg == BYTE_CNT_LAST) & host_write
                        & (wr_cnt_reg == BYTE_CNT_LAST);
    wire ram_start    = (state_reg == ECMBX_IDLE) & (ram_req.read_req | ram_req.write_req);
    wire [23:0] in_mbx_new = {sys_bus_in, in_mbx_reg[15:0]};

    // ==========================================================
    // Engine: RAM cycles own the bus, exchanges start only from the core
    // A host that never finishes stalls the engine; there is no timeout here
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ECMBX_IDLE: begin
                if (ram_start)
                    state_next = ECMBX_RAM;
                else if (send_valid)
                    state_next = ECMBX_OFFER;
            end
            ECMBX_RAM:   state_next = ECMBX_IDLE;
            ECMBX_OFFER: state_next = ECMBX_XFER;
            ECMBX_XFER: begin
                if (xfer_done)
                    state_next = ECMBX_ACK;
            end
            ECMBX_ACK:   state_next = ECMBX_IDLE;
            default:     state_next = ECMBX_IDLE;
        endcase
    end

    // State, strobe history and half-rate divider
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= ECMBX_IDLE;
            strobe_d_reg <= 1'b0;
            half_clk_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            strobe_d_reg <= strobe_on;
            half_clk_reg <= ~half_clk_reg;
        end
    end

    // ==========================================================
    // Outgoing shift register: low byte leaves first
    // Third and later reads get no new byte; the count stops at the last index
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_mbx_reg <= 24'h000000;
            rd_cnt_reg  <= 2'h0;
            bus_out_reg <= 8'h00;
        end else if (state_reg == ECMBX_IDLE && !ram_start && send_valid) begin
            out_mbx_reg <= send_word;
            rd_cnt_reg  <= 2'h0;
        end else if (host_read && rd_cnt_reg != BYTE_CNT_LAST) begin
            bus_out_reg <= out_mbx_reg[7:0];
            out_mbx_reg <= {8'h00, out_mbx_reg[23:8]};
            rd_cnt_reg  <= rd_cnt_reg + 2'h1;
        end else if (ram_start) begin
            bus_out_reg <= ram_req.addr[7:0];
        end
    end

    // ==========================================================
    // Incoming register: bytes fill low to high, word posted on the third
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_mbx_reg     <= 24'h000000;
            wr_cnt_reg     <= 2'h0;
            recv_valid_reg <= 1'b0;
        end else begin
            recv_valid_reg <= xfer_done;
            if (state_reg == ECMBX_OFFER)
                wr_cnt_reg <= 2'h0;
            else if (host_write) begin
                case (wr_cnt_reg)
                    2'h0:    in_mbx_reg[7:0]   <= sys_bus_in;
                    2'h1:    in_mbx_reg[15:8]  <= sys_bus_in;
                    default: in_mbx_reg[23:16] <= sys_bus_in;
                endcase
                if (wr_cnt_reg != BYTE_CNT_LAST)
                    wr_cnt_reg <= wr_cnt_reg + 2'h1;
            end
        end
    end

    // ==========================================================
    // Configuration sequence decoded from completed incoming words
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= '0;
        end else if (xfer_done) begin
            if (in_mbx_new == CFG_START_PAT) begin
                cfg_reg.configuring <= 1'b1;
                cfg_reg.delay_valid <= 1'b0;
            end else if (cfg_reg.configuring && !cfg_reg.delay_valid) begin
                cfg_reg.round_trip  <= in_mbx_new[15:0];
                cfg_reg.far_enable  <= in_mbx_new[16];
                cfg_reg.delay_valid <= (in_mbx_new[15:0] < DELAY_LIMIT);
            end else if (cfg_reg.delay_valid && in_mbx_new == CONV_START_PAT) begin
                cfg_reg.near_adapt <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Local RAM strobes, one cycle each; data captured on read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ram_write_reg <= 1'b0;
            rdata_reg     <= 16'h0000;
            rvalid_reg    <= 1'b0;
            ack_reg       <= 1'b0;
        end else begin
            ram_write_reg <= ram_start & ram_req.write_req;
            rvalid_reg    <= (state_reg == ECMBX_RAM) & ~ram_write_reg;
            ack_reg       <= host_access;
            if (state_reg == ECMBX_RAM && !ram_write_reg)
                rdata_reg <= local_data_in;
        end
    end

    logic [15:0] wdata_reg;
    logic [3:0]  addr_hi_reg;
    // RAM address and write data held for the strobe cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wdata_reg   <= 16'h0000;
            addr_hi_reg <= 4'h0;
        end else if (ram_start) begin
            wdata_reg   <= ram_req.wdata;
            addr_hi_reg <= ram_req.addr[11:8];
        end
    end

    // ==========================================================
    // Pin drive; host owns the byte bus only during an exchange
    wire ram_cyc = (state_reg == ECMBX_RAM);
    assign half_rate_clock_output = half_clk_reg;
    assign sys_bus_out        = bus_out_reg;
    assign sys_bus_oe         = ram_cyc | (in_xfer & host_sel & strobe_on
                                & host_in.system_direction);
    assign bus_available      = in_xfer;
    assign attention_req_n    = ~in_xfer;
    assign transfer_ack_out_n = ~ack_reg;
    assign local_addr_hi      = addr_hi_reg;
    assign local_data_out     = wdata_reg;
    assign local_data_oe      = ram_cyc & ram_write_reg;
    assign local_read_n       = ~(ram_cyc & ~ram_write_reg);
    assign local_write_n      = ~(ram_cyc & ram_write_reg);
    assign ram_busy           = (state_reg != ECMBX_IDLE);
    assign ram_rdata          = rdata_reg;
    assign ram_rvalid         = rvalid_reg;
    assign send_ready         = (state_reg == ECMBX_IDLE) & ~ram_start;
    assign recv_word          = in_mbx_reg;
    assign recv_valid         = recv_valid_reg;
    assign cfg                = cfg_reg;

    // ==========================================================
    // Checks
    chk_half_clock_toggle: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> half_rate_clock_output != $past(half_rate_clock_output))
        else $error("half rate clock did not toggle");
    chk_ram_excl_bus: assert property (@(posedge sys_clk) disable iff (rst)
        ram_cyc |-> !bus_available && sys_bus_oe)
        else $error("host saw bus during ram cycle");
    chk_ram_strobe_one: assert property (@(posedge sys_clk) disable iff (rst)
        !(local_read_n == 1'b0 && local_write_n == 1'b0))
        else $error("both ram strobes active");
    chk_ack_follows: assert property (@(posedge sys_clk) disable iff (rst)
        host_access |=> !transfer_ack_out_n)
        else $error("no acknowledge after access");
    chk_no_unsolicited: assert property (@(posedge sys_clk) disable iff (rst)
        !in_xfer |-> attention_req_n && !bus_available)
        else $error("bus offered without exchange");
    chk_offer_request: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg == ECMBX_OFFER |=> !attention_req_n)
        else $error("request not raised after offer");
    chk_release_done: assert property (@(posedge sys_clk) disable iff (rst)
        xfer_done |=> attention_req_n ##1 attention_req_n)
        else $error("request held after exchange");
    chk_write_oe_off: assert property (@(posedge sys_clk) disable iff (rst)
        in_xfer && !host_in.system_direction |-> !sys_bus_oe)
        else $error("device drove bus on host write");
    chk_recv_post: assert property (@(posedge sys_clk) disable iff (rst)
        xfer_done |=> recv_valid && recv_word[23:16] == $past(sys_bus_in))
        else $error("incoming word not posted");
    chk_start_first: assert property (@(posedge sys_clk) disable iff (rst)
        !cfg.configuring |-> !cfg.near_adapt && !cfg.delay_valid)
        else $error("config accepted before start");

    // ==========================================================
    // Pin-level checks; these catch a broken capture even where the engine looks sane
    chk_ack_only_access: assert property (@(posedge sys_clk) disable iff (rst)
        !transfer_ack_out_n |-> $past(host_access))
        else $error("acknowledge without accepted access");
    chk_ram_addr_out: assert property (@(posedge sys_clk) disable iff (rst)
        ram_cyc |-> {local_addr_hi, sys_bus_out} == $past(ram_req.addr))
        else $error("ram address not on its pins");
    chk_read_strobe_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        !local_read_n |=> local_read_n)
        else $error("ram read strobe longer than one cycle");
    chk_deselect_no_ack: assert property (@(posedge sys_clk) disable iff (rst)
        in_xfer && host_in.host_select_n |=> transfer_ack_out_n)
        else $error("acknowledge while host deselected");
    chk_done_bus_free: assert property (@(posedge sys_clk) disable iff (rst)
        xfer_done |=> !bus_available && !sys_bus_oe)
        else $error("bus still offered after exchange");
    chk_offer_after_send: assert property (@(posedge sys_clk) disable iff (rst)
        send_valid && send_ready |-> ##2 !attention_req_n)
        else $error("exchange not opened after core offer");

    cov_exchange: cover property (@(posedge sys_clk) disable iff (rst) xfer_done);
    cov_ram_read: cover property (@(posedge sys_clk) disable iff (rst) rvalid_reg);
    cov_adapt: cover property (@(posedge sys_clk) disable iff (rst) $rose(cfg.near_adapt));
    cov_deselect: cover property (@(posedge sys_clk) disable iff (rst)
        in_xfer && host_in.host_select_n);
    // Write strobe seen at least once
    cov_ram_write: cover property (@(posedge sys_clk) disable iff (rst) !local_write_n);
endmodule // ecmbx_port

// *** sim/ecmbx_host.sv ***
// Host processor model that answers the mailbox handshake
`timescale 1ns/1ns
module ecmbx_host
    import ecmbx_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              attention_req_n,
    input  wire logic              transfer_ack_out_n,
    input  wire logic              slow,
    input  wire logic              stray,
    input  wire logic [7:0]        bus_wire,
    input  wire logic [23:0]       wr_word,
    output ecmbx_pkg::ecmbx_host_t host_in,
    output logic [7:0]             host_bus,
    output logic [15:0]            rd_word,
    output logic                   stray_ack
);
    logic [7:0] drv;
    logic [7:0] q;
    logic       wr_en;
    logic       ok;
    // ==========================================================
    // Released lines show the inverse of the last byte, so stale data never passes
    assign host_bus = wr_en ? drv : ~drv;
    // Hold the access until ack is sampled or 20 cycles pass, then release and sit deselected
    task automatic access(input logic rd, input logic [7:0] d);
        int n;
        host_in <= {1'b0, 1'b1, 1'b0, rd};
        drv     <= rd ? drv : d;
        wr_en   <= ~rd;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge sys_clk);
            ok = (transfer_ack_out_n === 1'b0);
        end
        q = bus_wire;
        host_in <= {1'b1, 1'b0, 1'b1, 1'b0};
        wr_en   <= 1'b0;
        repeat (slow ? 4 : 1) @(posedge sys_clk);
    endtask
    // Answer each invitation: low byte, high byte, then three writes
    initial begin
        host_in   = 4'b1010;
        drv       = 8'h00;
        wr_en     = 1'b0;
        rd_word   = 16'h0000;
        stray_ack = 1'bx;
        forever begin
            @(posedge sys_clk);
            if (attention_req_n === 1'b0) begin
                access(1'b1, 8'h00);
                rd_word[7:0] = q;
                access(1'b1, 8'h00);
                rd_word[15:8] = q;
                for (int k = 0; k < 3; k++) access(1'b0, wr_word[8*k +: 8]);
            end else if (stray) begin
                access(1'b0, 8'h5a);
                stray_ack = ok;
            end
        end
    end
endmodule // ecmbx_host

// *** sim/ecmbx_port_bench.sv ***
// Self-checking bench for the echo canceller host mailbox port
`timescale 1ns/1ns
module ecmbx_port_bench;
    import ecmbx_pkg::*;
    logic           sys_clk, rst, slow, stray, send_valid, prev, stray_ack;
    logic           half_rate_clock_output, sys_bus_oe, transfer_ack_out_n, bus_available;
    logic           attention_req_n, ram_busy, ram_rvalid, local_data_oe, local_read_n;
    logic           local_write_n, send_ready, recv_valid;
    logic [7:0]     bus_wire, host_bus, sys_bus_out;
    logic [23:0]    send_word, wr_word, recv_word;
    logic [15:0]    ram_val, ram_rdata, local_data_in, local_data_out, rd_word;
    logic [3:0]     local_addr_hi;
    logic [31:0]    r1, r2;
    ecmbx_host_t    host_in;
    ecmbx_ram_req_t ram_req;
    ecmbx_cfg_t     cfg;
    integer         seed, mismatches, num_checks;
    localparam int  LIM = 200;
    // ==========================================================
    // Two-way byte bus level and a RAM whose value shows only while read is strobed, inverted otherwise
    assign bus_wire = sys_bus_oe ? sys_bus_out : host_bus;
    assign local_data_in = local_read_n ? ~ram_val : ram_val;
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    ecmbx_port ecmbx_port_i (
        .sys_clk(sys_clk), .rst(rst), .half_rate_clock_output(half_rate_clock_output),
        .host_in(host_in), .sys_bus_in(bus_wire), .sys_bus_out(sys_bus_out),
        .sys_bus_oe(sys_bus_oe), .transfer_ack_out_n(transfer_ack_out_n),
        .bus_available(bus_available), .attention_req_n(attention_req_n), .ram_req(ram_req),
        .ram_busy(ram_busy), .ram_rdata(ram_rdata), .ram_rvalid(ram_rvalid),
        .local_data_in(local_data_in), .local_data_out(local_data_out),
        .local_data_oe(local_data_oe), .local_addr_hi(local_addr_hi),
        .local_read_n(local_read_n), .local_write_n(local_write_n), .send_valid(send_valid),
        .send_word(send_word), .send_ready(send_ready), .recv_word(recv_word),
        .recv_valid(recv_valid), .cfg(cfg));
    ecmbx_host ecmbx_host_i (
        .sys_clk(sys_clk), .attention_req_n(attention_req_n),
        .transfer_ack_out_n(transfer_ack_out_n), .slow(slow), .stray(stray),
        .bus_wire(bus_wire), .wr_word(wr_word), .host_in(host_in), .host_bus(host_bus),
        .rd_word(rd_word), .stray_ack(stray_ack));
    // ==========================================================
    // Comparison, verdict and bounded-wait helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic guard(input int n);
        if (n >= LIM) begin
            check("wait_bound", 0, 1);
            test_done();
        end
    endtask
    function automatic logic delay_ok(input logic [15:0] d);
        return d < DELAY_LIMIT;
    endfunction
    // One exchange offered by the core; the host model reads two bytes and writes three
    task automatic exchange(input logic [23:0] ow, input logic [23:0] iw, input logic s);
        int n;
        @(posedge sys_clk);
        send_word  <= ow;
        send_valid <= 1'b1;
        wr_word    <= iw;
        slow       <= s;
        for (n = 0; n < LIM && attention_req_n !== 1'b0; n++) @(posedge sys_clk);
        guard(n);
        check("bus_available", bus_available, 1);
        check("send_ready", send_ready, 0);
        send_valid <= 1'b0;
        for (n = 0; n < LIM && recv_valid !== 1'b1; n++) @(posedge sys_clk);
        guard(n);
        check("recv_word", recv_word, iw);
        check("host_read", rd_word, ow[15:0]);
        repeat (2) @(posedge sys_clk);
        check("req_release", {attention_req_n, bus_available}, 2'b10);
        check("idle_again", {ram_busy, send_ready}, 2'b01);
    endtask
    // Local RAM cycle: low address on the byte bus, high address on its own pins
    task automatic ram_op(input logic wr, input logic [11:0] a, input logic [15:0] d);
        int n;
        @(posedge sys_clk);
        ram_req <= {~wr, wr, a, d};
        ram_val <= r2[31:16];
        for (n = 0; n < LIM && (wr ? local_write_n : local_read_n) !== 1'b0; n++)
            @(posedge sys_clk);
        guard(n);
        ram_req <= '0;
        check("ram_addr_lo", {sys_bus_oe, sys_bus_out}, {1'b1, a[7:0]});
        check("ram_no_host", bus_available, 0);
        check("ram_busy", ram_busy, 1);
        check("ram_addr_hi", local_addr_hi, a[11:8]);
        if (wr) begin
            check("ram_wdata", {local_data_oe, local_data_out}, {1'b1, d});
        end else begin
            for (n = 0; n < LIM && ram_rvalid !== 1'b1; n++) @(posedge sys_clk);
            guard(n);
            check("ram_rdata", ram_rdata, ram_val);
        end
    endtask
    // Main sequence; random values are kept off both configuration patterns
    initial begin
        seed = 26;
        mismatches = 0;
        num_checks = 0;
        rst = 1'b1;
        {slow, stray, send_valid} = 3'b000;
        send_word = '0;
        wr_word = '0;
        ram_req = '0;
        ram_val = '0;
        repeat (2) @(posedge sys_clk);
        check("reset_idle", {transfer_ack_out_n, attention_req_n, sys_bus_oe}, 3'b110);
        rst <= 1'b0;
        repeat (4) begin
            @(posedge sys_clk);
            #1 prev = half_rate_clock_output;
            @(posedge sys_clk);
            #1 check("half_rate_clock", half_rate_clock_output, 1'(~prev));
        end
        @(posedge sys_clk);
        stray <= 1'b1;
        repeat (30) @(posedge sys_clk);
        stray <= 1'b0;
        repeat (30) @(posedge sys_clk);
        check("stray_ack", stray_ack, 0);
        for (int i = 0; i < 6; i++) begin
            r1 = $random(seed);
            r2 = $random(seed);
            ram_op(r1[31], r1[11:0], r2[15:0]);
            exchange(r1[23:0], {8'h55, r2[15:0]}, r1[24]);
        end
        check("cfg_idle", cfg.configuring, 0);
        exchange(r2[23:0], CFG_START_PAT, 1'b0);
        check("cfg_start", cfg.configuring, 1);
        exchange(r1[23:0], {8'h00, DELAY_LIMIT}, 1'b1);
        check("delay_limit", cfg.delay_valid, delay_ok(DELAY_LIMIT));
        exchange(r2[23:0], {8'h01, DELAY_LIMIT - 16'h0001}, 1'b0);
        check("delay_cfg", {cfg.delay_valid, cfg.round_trip, cfg.far_enable},
              {delay_ok(DELAY_LIMIT - 16'h0001), DELAY_LIMIT - 16'h0001, 1'b1});
        exchange(r1[23:0], CONV_START_PAT, 1'b1);
        check("near_adapt", cfg.near_adapt, 1);
        test_done();
    end
endmodule // ecmbx_port_bench
